// File: rtl/sma_pkg.sv
// Shared constants and types for the secure memory command host.
package sma_pkg;
   // Command bytes sent after a start condition.
   localparam logic [7:0] CMD_RD_CFG = 8'hB5;
   localparam logic [7:0] CMD_PWD = 8'hB3;
   localparam logic [7:0] CMD_IAUTH = 8'hB6;
   localparam logic [7:0] CMD_VAUTH = 8'hB7;
   // Configuration zone addresses of the attempts counters.
   localparam logic [7:0] PWD_CNT_BASE = 8'h40;
   localparam logic [7:0] AUTH_CNT_ADDR = 8'h20;
   // Payload sizes in bytes, the selector byte counted for passwords.
   localparam logic [3:0] PWD_BYTES = 4'h4;
   localparam logic [3:0] AUTH_BYTES = 4'h8;
   // Timing: one quarter of a serial clock period.
   localparam int CLK_NS = 40;
   localparam int SCL_QTR_NS = 250;
   localparam int QTR_CYC = (SCL_QTR_NS + CLK_NS - 1) / CLK_NS;
   // Operations the user side may request.
   typedef enum logic [1:0] {
      OP_PWD = 2'b00,
      OP_IAUTH = 2'b01,
      OP_VAUTH = 2'b10
   } sma_op_type;
   // Bit level states of the serial engine.
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_START = 3'b001,
      ST_BYTE = 3'b010,
      ST_STOP = 3'b011,
      ST_DONE = 3'b100
   } sma_st_type;
   // Byte level stage inside one operation.
   typedef enum logic [2:0] {
      SG_CMD = 3'b000,
      SG_DATA = 3'b001,
      SG_POLL = 3'b010,
      SG_ADDR = 3'b011,
      SG_READ = 3'b100
   } sma_sg_type;
   // A request: operation, password selector and payload.
   typedef struct packed {
      sma_op_type op;
      logic [3:0] sel;
      logic [63:0] data;
   } sma_cmd_type;
   // An answer: error flag and the attempts counter read back.
   typedef struct packed {
      logic err;
      logic [7:0] cnt;
   } sma_res_type;
endpackage : sma_pkg

// File: rtl/sma_host.sv
// Host controller that runs password and authentication commands.
// What this block does
// - Password command: 3 bytes plus rppp selector.
// - Poll read address, then send counter address.
// - Initialize authentication carries 8-byte random number.
// - No poll or counter read after initialize; done follows its stop.
// - Verify authentication carries 8-byte challenge.
// - Read authentication counter after polling read address.
// - Data changes only while clock low, except at start and stop.
// - Start: data falls, clock high, every command.
// - Missing host acknowledge ends a read.
// - Poll until device acknowledges finished write; error after POLL_LIMIT busy retries.
// - Clock held low while bus idle.
// - Bytes travel most significant bit first.
`timescale 1ns/1ps
module sma_host
   import sma_pkg::*;
#(
   parameter int POLL_LIMIT = 1000
) (
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic cmd_valid_i,
   input wire sma_cmd_type cmd_i,
   output logic cmd_ready_o,
   output logic done_o,
   output sma_res_type res_o,
   output logic scl_o,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o
);
   // Divider that paces the serial clock in quarter periods.
   logic [7:0] div_q;
   logic tick;
   // Two stage synchroniser for the data pin.
   logic sda_m_q;
   logic sda_s_q;
   // Engine state.
   sma_st_type st_q;
   sma_sg_type sg_q;
   sma_op_type op_q;
   logic [1:0] ph_q;
   logic [3:0] bit_q;
   logic [7:0] sh_q;
   logic [63:0] dat_q;
   logic [3:0] cnt_q;
   logic [7:0] addr_q;
   logic rb_q;
   logic fin_q;
   logic [15:0] poll_q;
   // Pin and user side registers.
   logic scl_q;
   logic scl_d;
   logic oe_q;
   logic oe_d;
   logic sda_q;
   logic rdy_q;
   logic done_q;
   sma_res_type res_q;
   // End of the last quarter of an acknowledge slot.
   logic t_end;
   logic ack_ok;

   assign tick = (div_q == 8'(QTR_CYC - 1));
   assign t_end = tick && st_q == ST_BYTE && bit_q == 4'h8 && ph_q == 2'd3;
   assign ack_ok = !sda_s_q;

   // The divider free-runs; a phase lasts QTR_CYC clocks, the quarter period rounded up.
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         div_q <= 8'h00;
      end else if (tick) begin
         div_q <= 8'h00;
      end else begin
         div_q <= div_q + 8'h01;
      end
   end

   // The pin is asynchronous to us, so only the second flop is read.
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         sda_m_q <= 1'b1;
         sda_s_q <= 1'b1;
      end else begin
         sda_m_q <= sda_i;
         sda_s_q <= sda_m_q;
      end
   end

   // Pin levels per state and phase. Outside start and stop, data moves only in the second
   // low quarter, so it never changes on the edge where the clock falls.
   always_comb begin
      scl_d = 1'b0;
      oe_d = oe_q;
      case (st_q)
         ST_START: begin
            scl_d = (ph_q == 2'd1) || (ph_q == 2'd2);
            if (ph_q == 2'd0) begin
               oe_d = 1'b0;
            end else if (ph_q == 2'd2) begin
               oe_d = 1'b1;
            end
         end
         ST_BYTE: begin
            scl_d = ph_q[1];
            if (ph_q == 2'd1) begin
               if (bit_q == 4'h8 || sg_q == SG_READ) begin
                  oe_d = 1'b0;
               end else begin
                  oe_d = !sh_q[7];
               end
            end
         end
         ST_STOP: begin
            scl_d = ph_q[1];
            if (ph_q == 2'd1) begin
               oe_d = 1'b1;
            end else if (ph_q == 2'd3) begin
               oe_d = 1'b0;
            end
         end
         default: begin
            scl_d = 1'b0;
            oe_d = 1'b0;
         end
      endcase
   end

   // Pin outputs come from flops; the pin is open drain, so only the
   // enable moves and the driven level is always low.
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         scl_q <= 1'b0;
         oe_q <= 1'b0;
         sda_q <= 1'b0;
      end else begin
         scl_q <= scl_d;
         oe_q <= oe_d;
         sda_q <= 1'b0;
      end
   end

   // Operation sequencer: start, command byte, payload, stop, then an
   // optional poll and counter read-back.
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         st_q <= ST_IDLE;
         sg_q <= SG_CMD;
         op_q <= OP_PWD;
         ph_q <= 2'd0;
         bit_q <= 4'h0;
         sh_q <= 8'h00;
         dat_q <= 64'h0;
         cnt_q <= 4'h0;
         addr_q <= 8'h00;
         rb_q <= 1'b0;
         fin_q <= 1'b0;
         poll_q <= 16'h0000;
         rdy_q <= 1'b0;
         done_q <= 1'b0;
         res_q <= '0;
      end else begin
         done_q <= 1'b0;
         case (st_q)
            ST_IDLE: begin
               rdy_q <= 1'b1;
               if (cmd_valid_i && rdy_q) begin
                  // Accept one request; the payload is shifted out later.
                  rdy_q <= 1'b0;
                  op_q <= cmd_i.op;
                  sg_q <= SG_CMD;
                  ph_q <= 2'd0;
                  fin_q <= 1'b0;
                  poll_q <= 16'h0000;
                  res_q <= '0;
                  st_q <= ST_START;
                  if (cmd_i.op == OP_PWD) begin
                     // Selector byte first, then the password value.
                     dat_q <= {4'h0, cmd_i.sel, cmd_i.data[23:0], 32'h0};
                     cnt_q <= PWD_BYTES;
                     addr_q <= PWD_CNT_BASE + {4'h0, cmd_i.sel};
                     rb_q <= 1'b1;
                  end else begin
                     dat_q <= cmd_i.data;
                     cnt_q <= AUTH_BYTES;
                     addr_q <= AUTH_CNT_ADDR;
                     rb_q <= (cmd_i.op == OP_VAUTH);
                  end
               end
            end
            ST_START: begin
               if (tick) begin
                  ph_q <= ph_q + 2'd1;
                  if (ph_q == 2'd3) begin
                     st_q <= ST_BYTE;
                     bit_q <= 4'h0;
                     if (sg_q == SG_POLL) begin
                        sh_q <= CMD_RD_CFG;
                     end else if (op_q == OP_PWD) begin
                        sh_q <= CMD_PWD;
                     end else if (op_q == OP_IAUTH) begin
                        sh_q <= CMD_IAUTH;
                     end else begin
                        sh_q <= CMD_VAUTH;
                     end
                  end
               end
            end
            ST_BYTE: begin
               if (tick) begin
                  ph_q <= ph_q + 2'd1;
                  if (ph_q == 2'd3 && bit_q != 4'h8) begin
                     // Shift out the sent bit, or shift in a read bit.
                     sh_q <= {sh_q[6:0], sda_s_q};
                     bit_q <= bit_q + 4'h1;
                  end
               end
               if (t_end) begin
                  bit_q <= 4'h0;
                  case (sg_q)
                     SG_CMD, SG_POLL: begin
                        if (!ack_ok) begin
                           // Device still busy: stop and poll again.
                           st_q <= ST_STOP;
                           poll_q <= poll_q + 16'h0001;
                           if (poll_q == 16'(POLL_LIMIT)) begin
                              fin_q <= 1'b1;
                              res_q.err <= 1'b1;
                           end
                        end else if (sg_q == SG_CMD) begin
                           sg_q <= SG_DATA;
                           sh_q <= dat_q[63:56];
                           dat_q <= {dat_q[55:0], 8'h00};
                           cnt_q <= cnt_q - 4'h1;
                        end else begin
                           sg_q <= SG_ADDR;
                           sh_q <= addr_q;
                        end
                     end
                     SG_DATA: begin
                        if (!ack_ok) begin
                           st_q <= ST_STOP;
                           fin_q <= 1'b1;
                           res_q.err <= 1'b1;
                        end else if (cnt_q == 4'h0) begin
                           st_q <= ST_STOP;
                           fin_q <= !rb_q;
                           sg_q <= SG_POLL;
                           poll_q <= 16'h0000;
                        end else begin
                           sh_q <= dat_q[63:56];
                           dat_q <= {dat_q[55:0], 8'h00};
                           cnt_q <= cnt_q - 4'h1;
                        end
                     end
                     SG_ADDR: begin
                        if (!ack_ok) begin
                           st_q <= ST_STOP;
                           fin_q <= 1'b1;
                           res_q.err <= 1'b1;
                        end else begin
                           sg_q <= SG_READ;
                           sh_q <= 8'h00;
                        end
                     end
                     default: begin
                        // One byte read, left unacknowledged to end it.
                        res_q.cnt <= sh_q;
                        st_q <= ST_STOP;
                        fin_q <= 1'b1;
                     end
                  endcase
               end
            end
            ST_STOP: begin
               if (tick) begin
                  ph_q <= ph_q + 2'd1;
                  if (ph_q == 2'd3) begin
                     st_q <= fin_q ? ST_DONE : ST_START;
                  end
               end
            end
            default: begin
               done_q <= 1'b1;
               st_q <= ST_IDLE;
            end
         endcase
      end
   end

   assign cmd_ready_o = rdy_q;
   assign done_o = done_q;
   assign res_o = res_q;
   assign scl_o = scl_q;
   assign sda_o = sda_q;
   assign sda_oe_o = oe_q;

   // Checks on the pin sequence.
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rstn_i);

   property p_sda_hold;
      (st_q == ST_BYTE && $past(st_q) == ST_BYTE && scl_q && $past(scl_q))
         |-> oe_q == $past(oe_q);
   endproperty
   a_sda_hold: assert property (p_sda_hold) else $error("data moved with clock high");
   property p_start;
      (st_q == ST_START && ph_q == 2'd3) |-> oe_q;
   endproperty
   a_start: assert property (p_start) else $error("start did not pull data low");
   property p_stop;
      (st_q == ST_STOP && ph_q == 2'd3 && $past(ph_q) == 2'd3) |-> !oe_q && scl_q;
   endproperty
   a_stop: assert property (p_stop) else $error("stop did not release data high");
   property p_idle_low;
      (st_q == ST_IDLE && $past(st_q) == ST_IDLE) |-> !scl_q && !oe_q;
   endproperty
   a_idle_low: assert property (p_idle_low) else $error("clock not low when idle");
   property p_msb;
      (st_q == ST_BYTE && bit_q != 4'h8 && ph_q == 2'd2 && sg_q != SG_READ)
         |-> oe_q == !sh_q[7];
   endproperty
   a_msb: assert property (p_msb) else $error("wrong bit driven");
   property p_ack_free;
      (st_q == ST_BYTE && bit_q == 4'h8 && ph_q == 2'd2) |-> !oe_q;
   endproperty
   a_ack_free: assert property (p_ack_free) else $error("ack slot not released");
   property p_read_free;
      (st_q == ST_BYTE && sg_q == SG_READ && ph_q == 2'd2) |-> !oe_q;
   endproperty
   a_read_free: assert property (p_read_free) else $error("host drove during read");
   property p_poll_cmd;
      (st_q == ST_BYTE && sg_q == SG_POLL && bit_q == 4'h0) |-> sh_q == CMD_RD_CFG;
   endproperty
   a_poll_cmd: assert property (p_poll_cmd) else $error("poll byte wrong");
   property p_vauth_cmd;
      (st_q == ST_BYTE && sg_q == SG_CMD && op_q == OP_VAUTH && bit_q == 4'h0)
         |-> sh_q == CMD_VAUTH;
   endproperty
   a_vauth_cmd: assert property (p_vauth_cmd) else $error("verify byte wrong");
   property p_retry;
      (t_end && sg_q == SG_POLL && !ack_ok) |=> st_q == ST_STOP;
   endproperty
   a_retry: assert property (p_retry) else $error("no retry after busy poll");

   c_pwd: cover property (done_q && op_q == OP_PWD && !res_q.err);
   c_vauth: cover property (done_q && op_q == OP_VAUTH);
   c_busy: cover property (t_end && sg_q == SG_POLL && !ack_ok);
endmodule : sma_host

// File: verification/sma_dev_model.sv
// Behavioural model of the secure memory device on the two-wire link.
`timescale 1ns/1ps
module sma_dev_model
   import sma_pkg::*;
#(
   parameter int WR_NS = 20000
) (
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_oe_o
);
   logic [23:0] pwd_store [16]; // Stored passwords, loaded by the bench.
   logic [7:0] pwd_cnt [16]; // Password attempts counters, loaded by the bench.
   logic [7:0] auth_cnt = 8'hFF; // Authentication attempts counter.
   logic [63:0] crypt; // Session cryptogram, loaded by the bench.
   logic [63:0] buf_q = '0; // Payload bytes gathered after the command.
   logic [7:0] sh = '0; // Receive shift register.
   logic [7:0] cmd = '0; // Command of the open frame, zero when none.
   logic [7:0] rb = '0; // Byte being read out.
   logic [3:0] act = '0; // The one password that is active.
   int cnt = 0; // Clock count inside the current byte.
   int idx = 0; // Bytes accepted in the current frame.
   int wr_ns = WR_NS; // Write cycle length; the bench may stretch it.
   bit rd = 1'b0; // Set while a byte is being read out.
   bit rd_pend = 1'b0; // A read begins after the next acknowledge.
   bit auth_ok = 1'b0; // An initialize came before this verify.
   time busy_until = 0; // End of the running nonvolatile write cycle.
   initial sda_oe_o = 1'b0;

   // A byte has come in; the returned level says whether to acknowledge.
   function automatic logic take_byte();
      logic ok;
      ok = 1'b1;
      if (idx == 0) begin
         // Inputs stay deaf while a write cycle runs, so a poll is left high.
         ok = ($time >= busy_until);
         ok = ok && (sh inside {CMD_PWD, CMD_RD_CFG, CMD_IAUTH, CMD_VAUTH});
         if (ok) cmd = sh;
      end else if (cmd == CMD_PWD && idx == 1) begin
         act = sh[3:0];
      end else if (cmd == CMD_RD_CFG) begin
         rb = (sh == AUTH_CNT_ADDR) ? auth_cnt : pwd_cnt[4'(sh - PWD_CNT_BASE)];
         rd_pend = 1'b1;
      end else begin
         buf_q = {buf_q[55:0], sh};
      end
      if (ok) idx = idx + 1;
      return ok;
   endfunction : take_byte

   // At a stop the completed command starts its write cycle.
   task automatic finish_cmd();
      if (cmd == CMD_PWD && idx == 5) begin
         if (pwd_cnt[act] != 8'h00) begin
            if (buf_q[23:0] == pwd_store[act]) pwd_cnt[act] = 8'hFF;
            else pwd_cnt[act] = {pwd_cnt[act][6:0], 1'b0};
         end
         busy_until = $time + wr_ns;
      end else if (cmd == CMD_IAUTH && idx == 9) begin
         auth_ok = (auth_cnt != 8'h00);
         if (auth_ok) auth_cnt = {auth_cnt[6:0], 1'b0};
         busy_until = $time + wr_ns;
      end else if (cmd == CMD_VAUTH && idx == 9) begin
         if (auth_ok && auth_cnt != 8'h00 && buf_q == crypt + 64'h1) begin
            crypt = crypt + 64'h2;
            auth_cnt = 8'hFF;
         end
         auth_ok = 1'b0;
         busy_until = $time + wr_ns;
      end
      cmd = 8'h00;
   endtask : finish_cmd

   // A falling data line while the clock is high opens a frame.
   always @(negedge sda_i) begin
      if (scl_i === 1'b1) begin
         cnt = 0;
         idx = 0;
         cmd = 8'h00;
         rd = 1'b0;
      end
   end

   // A rising data line while the clock is high closes it; standby follows.
   always @(posedge sda_i) begin
      if (scl_i === 1'b1) begin
         cnt = 0;
         rd = 1'b0;
         if ($time >= busy_until) finish_cmd();
      end
   end

   // Data is taken on the rising clock, most significant bit first.
   always @(posedge scl_i) begin
      if (cnt < 8) begin
         sh = {sh[6:0], sda_i};
         cnt = cnt + 1;
      end else begin
         if (rd && sda_i) rd = 1'b0;
         cnt = 0;
      end
   end

   // The device changes the line only while the clock is low.
   always @(negedge scl_i) begin
      if (rd_pend && cnt == 0) begin
         rd = 1'b1;
         rd_pend = 1'b0;
      end
      if (rd) sda_oe_o = (cnt < 8) ? ~rb[7 - cnt] : 1'b0;
      else if (cnt == 8) sda_oe_o = take_byte();
      else sda_oe_o = 1'b0;
   end
endmodule : sma_dev_model

// File: verification/sma_host_tb_top.sv
// Self-checking bench of the secure memory command host.
`timescale 1ns/1ps
module sma_host_tb_top;
   import sma_pkg::*;
   localparam int LIMIT = 60000; // Cycle ceiling of the whole run.
   logic clk_i = 1'b0;
   logic rstn_i = 1'b0;
   logic cmd_valid_i = 1'b0;
   sma_cmd_type cmd_i = '0;
   logic cmd_ready_o, done_o, scl_o, sda_o, sda_oe_o, dev_oe, sda_w;
   sma_res_type res_o;
   int failures = 0;
   int check_count = 0;
   int cyc = 0;
   logic [23:0] pwd_ref [16]; // Reference passwords.
   logic [7:0] pwd_cnt_ref [16]; // Reference password counters.
   logic [7:0] auth_cnt_ref = 8'hFF; // Reference authentication counter.
   logic [63:0] crypt_ref = 64'h0123_4567_89AB_CDEF; // Reference cryptogram.
   bit init_m = 1'b0; // Reference flag of a pending initialize.
   logic [31:0] r;
   logic [3:0] s;
   logic [63:0] d;

   always #20 clk_i = ~clk_i;
   // The data line has a pull-up; either party may pull it low.
   assign sda_w = ~((sda_oe_o & ~sda_o) | dev_oe);

   sma_host #(.POLL_LIMIT(5)) dut (.clk_i(clk_i), .rstn_i(rstn_i), .cmd_valid_i(cmd_valid_i),
      .cmd_i(cmd_i), .cmd_ready_o(cmd_ready_o), .done_o(done_o), .res_o(res_o),
      .scl_o(scl_o), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe_o));
   sma_dev_model dev (.scl_i(scl_o), .sda_i(sda_w), .sda_oe_o(dev_oe));

   // Prints the counts and the verdict, then stops the run.
   task automatic end_of_test();
      $display("Checks %0d mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : end_of_test

   // Compares one flag.
   task automatic chk1(input string what, input logic exp, input logic got);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("BAD %s expected %b seen %b", what, exp, got);
      end
   endtask : chk1

   // Compares one byte.
   task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask : chk8

   // Runs one request to its done pulse and checks it against the model.
   task automatic run_op(input sma_op_type op, input logic [3:0] sel, input logic [63:0] dat,
      input bit ex_err);
      int n;
      n = 0;
      while (cmd_ready_o !== 1'b1) begin
         @(posedge clk_i);
         #1;
      end
      cmd_i = '{op: op, sel: sel, data: dat};
      cmd_valid_i = 1'b1;
      @(posedge clk_i);
      #1;
      cmd_valid_i = 1'b0;
      while (done_o !== 1'b1 && n < 20000) begin
         @(posedge clk_i);
         #1;
         n++;
      end
      chk1("done", 1'b1, done_o);
      chk1("err", ex_err, res_o.err);
      chk1("scl_idle", 1'b0, scl_o);
      chk1("sda_free", 1'b0, sda_oe_o);
      chk1("sda_level", 1'b0, sda_o);
      if (ex_err) return;
      case (op)
         OP_PWD: begin
            if (pwd_cnt_ref[sel] != 8'h00) begin
               if (dat[23:0] == pwd_ref[sel]) pwd_cnt_ref[sel] = 8'hFF;
               else pwd_cnt_ref[sel] = pwd_cnt_ref[sel] << 1;
            end
            chk8("pwd_cnt", pwd_cnt_ref[sel], res_o.cnt);
         end
         OP_IAUTH: begin
            init_m = (auth_cnt_ref != 8'h00);
            if (init_m) auth_cnt_ref = auth_cnt_ref << 1;
            chk8("iauth_cnt", 8'h00, res_o.cnt);
         end
         default: begin
            if (init_m && auth_cnt_ref != 8'h00 && dat == crypt_ref + 64'h1) begin
               crypt_ref = crypt_ref + 64'h2;
               auth_cnt_ref = 8'hFF;
            end
            init_m = 1'b0;
            chk8("auth_cnt", auth_cnt_ref, res_o.cnt);
         end
      endcase
      @(posedge clk_i);
      #1;
      chk1("ready_again", 1'b1, cmd_ready_o);
   endtask : run_op

   // Cuts a hung run short.
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == LIMIT) begin
         failures++;
         end_of_test();
      end
   end

   // Main sequence: authentication, random passwords, exhaustion, slow write.
   initial begin
      void'($urandom(31481));
      for (int i = 0; i < 16; i++) begin
         pwd_ref[i] = 24'($urandom);
         // Six bits already used up, so two wrong tries exhaust set 7.
         pwd_cnt_ref[i] = (i == 7) ? 8'hC0 : 8'hFF;
         dev.pwd_store[i] = pwd_ref[i];
         dev.pwd_cnt[i] = pwd_cnt_ref[i];
      end
      dev.crypt = crypt_ref;
      // The first edge in reset settles every flop of the host.
      @(posedge clk_i);
      #1;
      chk1("ready_in_reset", 1'b0, cmd_ready_o);
      chk1("scl_in_reset", 1'b0, scl_o);
      @(posedge clk_i);
      #1;
      rstn_i = 1'b1;
      run_op(OP_VAUTH, 4'h0, crypt_ref + 64'h1, 1'b0);
      run_op(OP_IAUTH, 4'h0, {$urandom, $urandom}, 1'b0);
      run_op(OP_VAUTH, 4'h0, crypt_ref + 64'h1, 1'b0);
      run_op(OP_IAUTH, 4'h0, {$urandom, $urandom}, 1'b0);
      run_op(OP_VAUTH, 4'h0, crypt_ref + 64'h3, 1'b0);
      // Alternate write and read passwords; set 7 is kept for exhaustion.
      for (int k = 0; k < 5; k++) begin
         r = $urandom;
         s = {1'(k), 3'(r[6:4] % 3'd7)};
         d = {40'h0, pwd_ref[s] ^ (r[8] ? 24'h0 : 24'h000001)};
         run_op(OP_PWD, s, d, 1'b0);
      end
      for (int k = 0; k < 3; k++) begin
         d = {40'h0, pwd_ref[7] ^ ((k < 2) ? 24'h800000 : 24'h0)};
         run_op(OP_PWD, 4'h7, d, 1'b0);
      end
      dev.wr_ns = 100000000;
      run_op(OP_PWD, 4'h1, {40'h0, pwd_ref[1]}, 1'b1);
      end_of_test();
   end
endmodule : sma_host_tb_top
